/* File: rtl/sdram_burst_access_core.sv */
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module sdram_burst_access_core import sdram_core_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        cke,
  input  wire logic        chip_select_n,
  input  wire logic        row_strobe_n,
  input  wire logic        column_strobe_n,
  input  wire logic        write_enable_n,
  input  wire logic        bank_select_low,
  input  wire logic        bank_select_high,
  input  wire logic [9:0]  address_low,
  input  wire logic        address_ten_autoclose,
  input  wire logic [1:0]  address_high,
  input  wire logic        low_byte_mask,
  input  wire logic        high_byte_mask,
  input  wire logic [15:0] data_bus_in,
  output logic      [15:0] data_bus_out,
  output logic      [1:0]  data_bus_oe,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp
);

  // highest burst count for a length code, also the wrap mask
  function automatic logic [COL_W-1:0] wrap_mask(input logic [2:0] code);
    // reserved codes act as single word
    wrap_mask = (code == 3'h7) ? 9'h1FF : (code < 3'h4) ? 9'((9'h001 << code) - 9'h001) : 9'h000;
  endfunction : wrap_mask

  // column of the n-th beat, wrapping inside the burst block
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start, input logic [COL_W-1:0] cnt,
                                                 input logic [2:0] code, input logic ilv);
    logic [COL_W-1:0] m;
    m = wrap_mask(code);
    if (ilv) begin
      burst_col = start ^ (cnt & m);
    end else begin
      burst_col = (start & ~m) | ((start + cnt) & m);
    end
  endfunction : burst_col

  pin_sample_t raw_pins;             // pins as bundle
  pin_sample_t pin_meta;             // first sync stage, read only by pin_now
  pin_sample_t pin_now;              // synchronised sample

  // pins are asynchronous to core_clk; two flops before any decode
  always_comb begin
    raw_pins = {cke, chip_select_n, row_strobe_n, column_strobe_n, write_enable_n,
                bank_select_high, bank_select_low, address_high, address_ten_autoclose,
                address_low, high_byte_mask, low_byte_mask, data_bus_in};
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_meta <= '1; // deselected, clock enabled, masked
      pin_now  <= '1;
    end else begin
      pin_meta <= raw_pins;
      pin_now  <= pin_meta;
    end
  end

  // core state
  word_t            mem [MEM_DEPTH];      // data storage, not reset
  logic [3:0]       bank_open;            // per-bank row open
  logic [ROW_W-1:0] bank_row [4];         // open row of each bank
  logic [ROW_W-1:0] mode;                 // programmed mode word
  logic             burst_on;             // a burst continues next cycle
  logic             burst_wr;             // running burst is a write
  logic [1:0]       burst_bank;
  logic [COL_W-1:0] burst_start;          // first column of the burst
  logic [COL_W-1:0] burst_cnt;            // beat index to use next
  logic [2:0]       burst_code;           // length code latched at start
  logic             burst_ilv;
  logic             burst_close;          // close row when burst ends
  power_t           power;
  logic             rd_v0, rd_v1;         // read pipeline valid
  word_t            rd_d0, rd_d1;         // read pipeline data
  logic [1:0]       mask_d;               // read mask, one cycle late
  logic [31:0]      refresh_count;        // refreshes seen while idle
  logic             ctrl_lowpwr;          // self refresh variant select

  logic [3:0]       next_bank_open;
  logic [ROW_W-1:0] next_bank_row [4];
  logic [ROW_W-1:0] next_mode;
  logic             next_burst_on, next_burst_wr, next_burst_ilv, next_burst_close;
  logic [1:0]       next_burst_bank;
  logic [COL_W-1:0] next_burst_start, next_burst_cnt;
  logic [2:0]       next_burst_code;
  power_t           next_power;
  logic             next_rd_v0, next_rd_v1;
  word_t            next_rd_d0, next_rd_d1, next_data_out;
  logic [1:0]       next_mask_d, next_oe;
  logic [31:0]      next_refresh_count;

  // the access done this cycle: a new column command or the running burst
  logic             acc_on, acc_wr, acc_ilv, acc_close;
  logic [1:0]       acc_bank;
  logic [COL_W-1:0] acc_start, acc_cnt, acc_col;
  logic [2:0]       acc_code, cmd;
  logic             run;
  logic             mem_we;
  logic [MEM_IDX_W-1:0] mem_idx;

  // command decode, bursts, read pipeline, power modes
  always_comb begin
    next_bank_open     = bank_open;
    next_bank_row      = bank_row;
    next_mode          = mode;
    next_burst_on      = burst_on;
    next_burst_cnt     = burst_cnt;
    next_power         = power;
    next_rd_v0         = rd_v0;
    next_rd_v1         = rd_v1;
    next_rd_d0         = rd_d0;
    next_rd_d1         = rd_d1;
    next_mask_d        = mask_d;
    next_data_out      = data_bus_out;
    next_oe            = data_bus_oe;
    next_refresh_count = refresh_count;
    acc_on    = burst_on;
    acc_wr    = burst_wr;
    acc_bank  = burst_bank;
    acc_start = burst_start;
    acc_cnt   = burst_cnt;
    acc_code  = burst_code;
    acc_ilv   = burst_ilv;
    acc_close = burst_close;
    acc_col   = '0;
    mem_we    = 1'b0;
    mem_idx   = '0;
    cmd = {pin_now.ras_n, pin_now.cas_n, pin_now.we_n};
    // exit from any low power state costs one cycle with nothing decoded
    run = pin_now.cke && (power == PWR_ON);
    if (!pin_now.cke) begin
      if (power == PWR_ON) begin
        if (burst_on || rd_v0 || rd_v1) begin
          next_power = PWR_SUSPEND;
        end else if (!pin_now.cs_n && cmd == CMD_REFRESH) begin
          next_power = ctrl_lowpwr ? PWR_SELF_LOW : PWR_SELF_STD;
        end else begin
          next_power = PWR_DOWN;
        end
      end
    end else begin
      next_power = PWR_ON;
    end
    if (run && !pin_now.cs_n) begin
      case (cmd)
        CMD_MODE: begin
          if (bank_open == 4'h0) begin
            next_mode = pin_now.addr;
          end
        end
        CMD_REFRESH: begin
          if (bank_open == 4'h0) begin
            next_refresh_count = refresh_count + 32'h1;
          end
        end
        CMD_ACTIVATE: begin
          next_bank_open[pin_now.bank] = 1'b1;
          next_bank_row[pin_now.bank]  = pin_now.addr;
        end
        CMD_PRECHARGE: begin
          if (pin_now.addr[AUTOCLOSE_BIT]) begin
            next_bank_open = 4'h0;
          end else begin
            next_bank_open[pin_now.bank] = 1'b0;
          end
          // precharge cuts a burst running in the closed bank
          if (pin_now.addr[AUTOCLOSE_BIT] || burst_bank == pin_now.bank) begin
            acc_on = 1'b0;
          end
        end
        CMD_WRITE, CMD_READ: begin
          // column command to a closed bank is dropped
          if (bank_open[pin_now.bank]) begin
            acc_on    = 1'b1;
            acc_wr    = (cmd == CMD_WRITE);
            acc_bank  = pin_now.bank;
            acc_start = pin_now.addr[COL_W-1:0];
            acc_cnt   = '0;
            acc_code  = (acc_wr && mode[MODE_WB_BIT]) ? 3'h0 : mode[MODE_BL_LSB +: 3];
            acc_ilv   = mode[MODE_BT_BIT];
            acc_close = pin_now.addr[AUTOCLOSE_BIT];
          end
        end
        CMD_STOP: begin
          acc_on = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // burst attributes follow the access; they equal the held ones when nothing new came
    next_burst_wr    = acc_wr;
    next_burst_bank  = acc_bank;
    next_burst_start = acc_start;
    next_burst_code  = acc_code;
    next_burst_ilv   = acc_ilv;
    next_burst_close = acc_close;
    // everything below freezes while the clock is suspended
    if (run) begin
      next_rd_v0 = 1'b0;
      if (acc_on) begin
        acc_col = burst_col(acc_start, acc_cnt, acc_code, acc_ilv);
        mem_idx = {acc_bank, bank_row[acc_bank][STORE_ROW_W-1:0], acc_col};
        if (acc_wr) begin
          mem_we = 1'b1;
        end else begin
          next_rd_v0 = 1'b1;
          next_rd_d0 = mem[mem_idx];
        end
        if (acc_cnt == wrap_mask(acc_code)) begin
          next_burst_on = 1'b0;
          if (acc_close) begin
            next_bank_open[acc_bank] = 1'b0;
          end
        end else begin
          next_burst_on  = 1'b1;
          next_burst_cnt = acc_cnt + 9'h001;
        end
      end else begin
        next_burst_on = 1'b0;
      end
      next_rd_v1  = rd_v0;
      next_rd_d1  = rd_d0;
      next_mask_d = pin_now.mask;
      // latency 2 taps the first stage, anything else the second
      if (mode[MODE_CL_LSB +: 3] == LAT_TWO) begin
        next_data_out = rd_d0;
        next_oe       = {2{rd_v0}} & ~mask_d;
      end else begin
        next_data_out = rd_d1;
        next_oe       = {2{rd_v1}} & ~mask_d;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bank_open     <= 4'h0;
      mode          <= MODE_RESET;
      burst_on      <= 1'b0; // burst attributes are only read while a burst runs
      power         <= PWR_ON;
      rd_v0         <= 1'b0;
      rd_v1         <= 1'b0;
      rd_d0         <= 16'h0000;
      rd_d1         <= 16'h0000;
      mask_d        <= 2'h3;
      data_bus_out  <= 16'h0000;
      data_bus_oe   <= 2'h0;
      refresh_count <= 32'h0000_0000;
    end else begin
      bank_open     <= next_bank_open;
      bank_row      <= next_bank_row;
      mode          <= next_mode;
      burst_on      <= next_burst_on;
      burst_wr      <= next_burst_wr;
      burst_bank    <= next_burst_bank;
      burst_start   <= next_burst_start;
      burst_cnt     <= next_burst_cnt;
      burst_code    <= next_burst_code;
      burst_ilv     <= next_burst_ilv;
      burst_close   <= next_burst_close;
      power         <= next_power;
      rd_v0         <= next_rd_v0;
      rd_v1         <= next_rd_v1;
      rd_d0         <= next_rd_d0;
      rd_d1         <= next_rd_d1;
      mask_d        <= next_mask_d;
      data_bus_out  <= next_data_out;
      data_bus_oe   <= next_oe;
      refresh_count <= next_refresh_count;
    end
  end

  // storage write, each byte blocked by its mask in the same cycle
  always_ff @(posedge core_clk) begin
    if (mem_we && !pin_now.mask[0]) begin
      mem[mem_idx][7:0] <= pin_now.din[7:0];
    end
    if (mem_we && !pin_now.mask[1]) begin
      mem[mem_idx][15:8] <= pin_now.din[15:8];
    end
  end

  // register bus slave; address and data may come in either order
  logic        aw_got, w_got, next_aw_got, next_w_got;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic        w_lane0, next_w_lane0;
  logic        next_ctrl_lowpwr, next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, status_word;

  always_comb begin
    next_aw_got      = aw_got;
    next_w_got       = w_got;
    next_aw_addr     = aw_addr;
    next_w_data      = w_data;
    next_w_lane0     = w_lane0;
    next_ctrl_lowpwr = ctrl_lowpwr;
    next_bvalid      = bvalid;
    next_bresp       = bresp;
    next_rvalid      = rvalid;
    next_rdata       = rdata;
    next_rresp       = rresp;
    status_word = 32'h0000_0000;
    status_word[STAT_OPEN_LSB +: 4]  = bank_open;
    status_word[STAT_BURST_BIT]      = burst_on;
    status_word[STAT_POWER_LSB +: 3] = power;
    if (awvalid && awready) begin
      next_aw_got  = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_got   = 1'b1;
      next_w_data  = wdata;
      next_w_lane0 = wstrb[0];
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    // commit only once both halves are held and the last response is gone
    if (aw_got && w_got && !bvalid) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      if (aw_addr == REG_CONTROL) begin
        next_bresp = RESP_OKAY;
        if (w_lane0) begin
          next_ctrl_lowpwr = w_data[CTRL_LOWPWR_BIT];
        end
      end else begin
        next_bresp = RESP_SLVERR; // read-only or unmapped
      end
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (araddr)
        REG_CONTROL: next_rdata = {31'h0000_0000, ctrl_lowpwr};
        REG_STATUS:  next_rdata = status_word;
        REG_MODE:    next_rdata = {19'h00000, mode};
        REG_REFRESH: next_rdata = refresh_count;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready  = !next_w_got && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_got      <= 1'b0;
      w_got       <= 1'b0;
      ctrl_lowpwr <= CTRL_RESET;
      awready     <= 1'b0;
      wready      <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
      arready     <= 1'b0;
      rvalid      <= 1'b0;
      rdata       <= 32'h0000_0000;
      rresp       <= RESP_OKAY;
    end else begin
      aw_got      <= next_aw_got;
      w_got       <= next_w_got;
      aw_addr     <= next_aw_addr;
      w_data      <= next_w_data;
      w_lane0     <= next_w_lane0;
      ctrl_lowpwr <= next_ctrl_lowpwr;
      awready     <= next_awready;
      wready      <= next_wready;
      bvalid      <= next_bvalid;
      bresp       <= next_bresp;
      arready     <= next_arready;
      rvalid      <= next_rvalid;
      rdata       <= next_rdata;
      rresp       <= next_rresp;
    end
  end
endmodule : sdram_burst_access_core
`default_nettype wire

/* File: rtl/sdram_core_pkg.sv */
// Behaviour
// - four banks of sixteen-bit words
// - bursts of 1, 2, 4, 8 or page
// - internal counter makes later burst columns
// - new column read accepted every cycle
// - mode register holds length, latency, ordering
// - read latency two or three cycles
// - burst read with single word writes
// - separate masks for low and high byte
// - auto precharge and explicit precharge
// - banks precharge and activate independently
// - self refresh standard, low power; power down
// - command decoded from strobes under chip select
// - read mask floats two later, write blocks now
// - clock enable low picks power mode
`default_nettype none
package sdram_core_pkg;
  localparam int COL_W       = 9;                       // column address width
  localparam int ROW_W       = 13;                      // row address width
  localparam int STORE_ROW_W = 2;                       // row address bits actually held per bank in flops
  localparam int MEM_IDX_W   = 2 + STORE_ROW_W + COL_W; // bank, row, column index
  localparam int MEM_DEPTH   = 1 << MEM_IDX_W;          // stored words

  typedef logic [15:0] word_t;                          // one data word

  // pin sample bundle
  typedef struct packed {
    logic             cke;
    logic             cs_n;
    logic             ras_n;
    logic             cas_n;
    logic             we_n;
    logic [1:0]       bank;
    logic [ROW_W-1:0] addr;
    logic [1:0]       mask;                             // high, low byte
    word_t            din;
  } pin_sample_t;

  // command codes on row strobe, column strobe, write enable
  localparam logic [2:0] CMD_MODE      = 3'h0;
  localparam logic [2:0] CMD_REFRESH   = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
  localparam logic [2:0] CMD_WRITE     = 3'h4;
  localparam logic [2:0] CMD_READ      = 3'h5;
  localparam logic [2:0] CMD_STOP      = 3'h6;
  localparam int AUTOCLOSE_BIT = 10;                    // address bit meaning close or all banks

  // mode register layout
  localparam int MODE_BL_LSB = 0;                       // burst length code, 3 bits
  localparam int MODE_BT_BIT = 3;                       // 1 = interleaved ordering
  localparam int MODE_CL_LSB = 4;                       // read latency, 3 bits
  localparam int MODE_WB_BIT = 9;                       // 1 = single word writes
  localparam logic [ROW_W-1:0] MODE_RESET = 13'h0020;   // latency 2, length 1, sequential
  localparam logic [2:0] LAT_TWO = 3'h2;

  typedef enum logic [2:0] {PWR_ON, PWR_DOWN, PWR_SUSPEND, PWR_SELF_STD, PWR_SELF_LOW} power_t;

  // software register map
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_MODE    = 8'h08;
  localparam logic [7:0] REG_REFRESH = 8'h0C;
  localparam int CTRL_LOWPWR_BIT = 0;
  localparam int STAT_OPEN_LSB   = 0;
  localparam int STAT_BURST_BIT  = 4;
  localparam int STAT_POWER_LSB  = 8;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sdram_core_pkg
`default_nettype wire

/* File: verification/sdram_core_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// watches the core's pins and register bus
module sdram_core_sva import sdram_core_pkg::*; (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        chip_select_n,
  input wire logic        row_strobe_n,
  input wire logic        column_strobe_n,
  input wire logic        write_enable_n,
  input wire logic        low_byte_mask,
  input wire logic        high_byte_mask,
  input wire logic [1:0]  data_bus_oe,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [7:0]  araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp
);
  logic [7:0] hist;       // read commands or masks seen lately
  logic [7:0] next_hist;  // shifted history
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // masks included: a fully masked beat may let the drive drop and return
  always_comb next_hist = {hist[6:0], (!chip_select_n && row_strobe_n && !column_strobe_n && write_enable_n)
                           || low_byte_mask || high_byte_mask};
  always_ff @(posedge core_clk) hist <= rst_n ? next_hist : 8'h00;
  chk_oe_reset: assert property ($rose(rst_n) |-> data_bus_oe == 2'h0)
    else $error("drive after reset");
  chk_oe_cause: assert property ($rose(|data_bus_oe) |-> |hist)
    else $error("drive without read");
  chk_b_time: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response late");
  chk_r_time: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  chk_b_once: assert property (bvalid && bready |=> !bvalid)
    else $error("bvalid repeated");
  chk_r_once: assert property (rvalid && rready |=> !rvalid)
    else $error("rvalid repeated");
  chk_busy_ready: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while busy");
  chk_ready_back: assert property (bvalid && bready |=> awready && wready)
    else $error("write ready not restored");
  chk_unmapped_read: assert property (arvalid && arready && araddr > 8'h0C |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : sdram_core_sva
bind sdram_burst_access_core sdram_core_sva i_sva (.*);
`default_nettype wire

/* File: verification/sdram_ctl_model.sv */
`timescale 1ns/1ns
`default_nettype none
// memory controller: one command per clock, changed just after the edge
module sdram_ctl_model import sdram_core_pkg::*; (
  input  wire logic        core_clk,
  output logic             cke,
  output logic             cs_n,
  output logic [2:0]       cmd,   // row strobe, column strobe, write enable
  output logic [1:0]       bank,
  output logic [ROW_W-1:0] addr,
  output logic [1:0]       mask,  // high, low byte
  output word_t            dq     // write data toward the device
);
  logic ce_next = 1'b1;  // clock enable taken with the next command
  initial {cke, cs_n, cmd, bank, addr, mask, dq} = {1'b1, 1'b0, 3'h7, 2'h0, 13'h0000, 2'h0, 16'h0000};
  task automatic set_cke(input logic v);
    ce_next = v;
  endtask : set_cke
  // a released data bus shows the inverse of its last value
  task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [ROW_W-1:0] a,
                       input logic [1:0] m, input word_t d, input logic w);
    @(posedge core_clk);
    cke <= ce_next;
    cmd <= c;
    bank <= b;
    addr <= a;
    mask <= m;
    dq <= w ? d : ~dq;
  endtask : issue
endmodule : sdram_ctl_model
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top import sdram_core_pkg::*;;
  logic core_clk = 1'b0, rst_n = 1'b0, cke, cs_n;
  logic [2:0] cmd;
  logic [1:0] bank, mask, oe, bresp, rresp;
  logic [ROW_W-1:0] addr;
  word_t dq, dout, din;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [17:0] q_beat[$];   // expected {drive, data} per beat
  logic [33:0] q_axi[$];    // expected {resp, data}
  word_t mem[int];          // reference storage
  logic [1:0] row_of[4];    // open row per bank
  int n_fail = 0, n_compared = 0, cyc = 0, n, s;
  logic [1:0] b;
  // the wire: the device's enabled bytes win over the controller
  assign din = {oe[1] ? dout[15:8] : dq[15:8], oe[0] ? dout[7:0] : dq[7:0]};
  always #25 core_clk = ~core_clk;
  sdram_ctl_model i_ctl (.core_clk, .cke, .cs_n, .cmd, .bank, .addr, .mask, .dq);
  sdram_burst_access_core i_dut (.core_clk, .rst_n, .cke, .chip_select_n(cs_n),
    .row_strobe_n(cmd[2]), .column_strobe_n(cmd[1]), .write_enable_n(cmd[0]), .bank_select_low(bank[0]),
    .bank_select_high(bank[1]), .address_low(addr[9:0]), .address_ten_autoclose(addr[10]),
    .address_high(addr[12:11]), .low_byte_mask(mask[0]), .high_byte_mask(mask[1]), .data_bus_in(din),
    .data_bus_out(dout), .data_bus_oe(oe), .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  task automatic summarize();
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic cmp_beat(input logic [17:0] e, g);
    n_compared++;
    if (e !== g) begin
      n_fail++;
      $display("mismatch beat exp %h got %h", e, g);
    end
  endtask : cmp_beat
  task automatic cmp_axi(input logic [33:0] e, g);
    n_compared++;
    if (e !== g) begin
      n_fail++;
      $display("mismatch axi exp %h got %h", e, g);
    end
  endtask : cmp_axi
  // result watcher: an unexpected beat meets an all-zero note
  always @(posedge core_clk) begin
    if (rst_n && oe != 2'h0) cmp_beat(q_beat.size() ? q_beat.pop_front() : 18'h0,
                                      {oe, dout & {{8{oe[1]}}, {8{oe[0]}}}});
    if (bvalid && bready) cmp_axi(q_axi.pop_front(), {bresp, 32'h0});
    if (rvalid && rready) cmp_axi(q_axi.pop_front(), {rresp, rdata});
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q_axi.push_back({r, 32'h0});
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    q_axi.push_back({r, d});
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : axi_rd
  task automatic nop(input int k);
    repeat (k) i_ctl.issue(3'h7, 2'h0, '0, 2'h0, 16'h0, 1'b0);
  endtask : nop
  function automatic int col_at(input int st, input int k, input int len, input logic ilv);
    return ilv ? (st ^ k) : ((st & ~(len - 1)) | ((st + k) & (len - 1)));
  endfunction : col_at
  task automatic set_mode(input logic [ROW_W-1:0] w);
    i_ctl.issue(CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0, 16'h0, 1'b0);
    i_ctl.issue(CMD_MODE, 2'h0, w, 2'h0, 16'h0, 1'b0);
    nop(4);
  endtask : set_mode
  task automatic activate(input logic [1:0] bk, input logic [1:0] r);
    row_of[bk] = r;
    i_ctl.issue(CMD_ACTIVATE, bk, {11'h0, r}, 2'h0, 16'h0, 1'b0);
  endtask : activate
  // two extra data cycles past the burst must not be stored
  task automatic wr_burst(input logic [1:0] bk, input int st, input int len, input logic ilv, input int keep);
    word_t d;
    logic [1:0] m;
    int a;
    for (int k = 0; k < len + 2; k++) begin
      d = word_t'($urandom);
      m = (keep == 1) ? 2'($urandom_range(0, 2)) : 2'h0;
      a = bk * 2048 + row_of[bk] * 512 + col_at(st, k, len, ilv);
      if (k < keep && !m[0]) mem[a][7:0] = d[7:0];
      if (k < keep && !m[1]) mem[a][15:8] = d[15:8];
      i_ctl.issue(k == 0 ? CMD_WRITE : 3'h7, bk, 13'(st), m, d, 1'b1);
    end
  endtask : wr_burst
  // a read mask acts two cycles on, so at latency 3 beat k carries the mask of cycle k+1
  task automatic rd_burst(input logic [1:0] bk, input int st, input int len, input logic ilv, input logic cl,
                          input int lat = 2);
    logic [1:0] m[514];
    word_t e;
    for (int k = 0; k <= len; k++) m[k] = (k < len) ? 2'($urandom_range(0, 2)) : 2'h0;
    for (int k = 0; k < len; k++) begin
      e = mem[bk * 2048 + row_of[bk] * 512 + col_at(st, k, len, ilv)];
      q_beat.push_back({~m[k + lat - 2], e & {{8{~m[k + lat - 2][1]}}, {8{~m[k + lat - 2][0]}}}});
      i_ctl.issue(k == 0 ? CMD_READ : 3'h7, bk, {2'h0, cl, 10'(st)}, m[k], 16'h0, 1'b0);
    end
  endtask : rd_burst
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    void'($urandom(32'h40E74638));
    axi_rd(REG_MODE, 32'h20);
    axi_rd(REG_CONTROL, 32'h0);
    axi_wr(REG_MODE, 32'h7, RESP_SLVERR);
    axi_rd(REG_MODE, 32'h20);
    axi_rd(8'h10, 32'h0, RESP_SLVERR);
    repeat (2) i_ctl.issue(CMD_REFRESH, 2'h0, '0, 2'h0, 16'h0, 1'b0);
    nop(6);
    axi_rd(REG_REFRESH, 32'h2);
    // every length, both orders, both latencies, two banks open at once
    for (int i = 0; i < 5; i++) begin
      n = (i == 4) ? 512 : (1 << i);
      b = 2'(i);
      set_mode({6'h0, i[0] ? 3'h3 : LAT_TWO, i[0] && i < 4, i == 4 ? 3'h7 : 3'(i)});
      activate(b, 2'($urandom_range(0, 3)));
      activate(2'(b + 1), 2'h1);
      s = $urandom_range(0, 511);
      wr_burst(b, s, n, i[0] && i < 4, n);
      rd_burst(b, s, n, i[0] && i < 4, 1'b0, i[0] ? 3 : 2);
      nop(12);
      axi_rd(REG_STATUS, 32'((4'h1 << b) | (4'h1 << 2'(b + 1))));
    end
    set_mode(13'h0020);
    activate(2'h0, row_of[0]);
    repeat (8) rd_burst(2'h0, $urandom_range(0, 511), 1, 1'b0, 1'b0);
    nop(8);
    set_mode(13'h0222);
    activate(2'h0, row_of[0]);
    s = $urandom_range(0, 511);
    wr_burst(2'h0, s, 4, 1'b0, 1);
    rd_burst(2'h0, s, 4, 1'b0, 1'b1);
    nop(10);
    i_ctl.issue(CMD_READ, 2'h0, 13'h5, 2'h0, 16'h0, 1'b0);
    activate(2'h1, 2'h2);
    activate(2'h2, 2'h3);
    i_ctl.issue(CMD_PRECHARGE, 2'h1, '0, 2'h0, 16'h0, 1'b0);
    nop(10);
    axi_rd(REG_STATUS, 32'h4);
    axi_wr(REG_CONTROL, 32'h1, RESP_OKAY);
    axi_rd(REG_CONTROL, 32'h1);
    i_ctl.issue(CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0, 16'h0, 1'b0);
    i_ctl.set_cke(1'b0);
    i_ctl.issue(CMD_REFRESH, 2'h0, '0, 2'h0, 16'h0, 1'b0);
    nop(4);
    axi_rd(REG_STATUS, 32'h400);
    i_ctl.set_cke(1'b1);
    nop(6);
    axi_rd(REG_STATUS, 32'h0);
    i_ctl.set_cke(1'b0);
    nop(6);
    axi_rd(REG_STATUS, 32'h100);
    i_ctl.set_cke(1'b1);
    nop(6);
    if (q_beat.size() != 0) begin
      n_fail++;
      $display("mismatch beats_left exp 0 got %0d", q_beat.size());
    end
    summarize();
  end
endmodule : tb_top
`default_nettype wire
